// ==== design/sclc_defs.vh ====
`ifndef SCLC_DEFS_VH
`define SCLC_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define SCLC_ADDR_W          16
`define SCLC_OFF_CARD_CTL    16'hfe0a
`define SCLC_OFF_EXT_CTL     16'hfe0b

// ****************************************
// card_line_control fields
// ****************************************
`define SCLC_CC_RST          7
`define SCLC_CC_IO           5
`define SCLC_CC_IOD          4
`define SCLC_CC_AUXU         3
`define SCLC_CC_AUXL         2
`define SCLC_CC_PARK         1
`define SCLC_CC_STOP         0

// ****************************************
// external_card_line_control fields
// ****************************************
`define SCLC_EC_IO           5
`define SCLC_EC_IOD          4
`define SCLC_EC_PARK         1
`define SCLC_EC_STOP         0

// ****************************************
// reset values
// ****************************************
`define SCLC_RST_CARD_CTL    8'h21
`define SCLC_RST_EXT_CTL     8'h00
`define SCLC_RDATA_NONE      8'h00

// ****************************************
// timing
// ****************************************
`define SCLC_SYNC_STAGES     2

`endif

// ==== design/sclc_edge_capture.v ====
// ****************************************
// captures a pin level at a clock rising edge
// ****************************************
// the pin passes two flip-flops; the edge strobe is delayed by the same
// two cycles so the sampled level is the one present at the edge itself
module sclc_edge_capture #(
  parameter RESET_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst_n,
  input  wire pin,
  input  wire edge_pulse,
  output reg  captured_q
);

  reg pin_s1_q;
  reg pin_s2_q;
  reg edge_d1_q;
  reg edge_d2_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q   <= 1'b0;
      pin_s2_q   <= 1'b0;
      edge_d1_q  <= 1'b0;
      edge_d2_q  <= 1'b0;
      captured_q <= RESET_VAL;
    end else begin
      pin_s1_q  <= pin;
      pin_s2_q  <= pin_s1_q;
      edge_d1_q <= edge_pulse;
      edge_d2_q <= edge_d1_q;
      if (edge_d2_q) begin
        captured_q <= pin_s2_q;
      end
    end
  end

endmodule

// ==== design/sclc_line_control.v ====
// Operation
// RULE1: outside sync mode, card reset line is low when control bit is 1.
// RULE2: card reset control bit acts in every mode, including warm reset.
// RULE3: firmware keeps reset control 0 while the activation sequencer runs.
// RULE4: in sync mode reset line follows the bit uninverted; reset length ignored.
// RULE5: reading the card data bit returns the raw, unsynchronised line level.
// RULE6: in bypass mode the written data bit is the level put on the line.
// RULE7: in sync mode data bit holds line level at latest card clock rise.
// RULE8: data direction bit: 1 input, 0 output (reset default), bypass and sync.
// RULE9: auxiliary contact as output drives written bit; read returns stored bit.
// RULE10: auxiliary contact as input reads raw level; write stores, never drives.
// RULE11: stopped card clock sits at the park level bit: 1 high, 0 low.
// RULE12: in bypass mode the park level bit sets the card clock line directly.
// RULE13: clock stop bit 0 runs, 1 stops at park level; no effect in bypass.
// RULE14: external data bit reads raw pin as input, drives pin as output.
// RULE15: in sync mode external data bit holds level at latest external clock rise.
// RULE16: external direction 1 input, 0 output; ignored unless bypass or sync; code still uses it outside sync to pick pin or written bit on read.
// RULE17: external clock stop bit 0 enables, 1 disables at park level; not bypass.
// RULE18: external park level sets stopped clock level and drives line in bypass.
// RULE19: firmware sequences external clock stop and start itself over the side bus.
// RULE20: after reset card control reads 0x21 and external control reads 0x00.
// RULE21: internal sync mode hands reset, data and aux buffers to register bits.
// RULE22: external sync mode hands external data buffer to register bits.
// RULE23: bypass, sync and auto-sequence modes arrive as inputs.
// RULE24: raw pin levels reach the read mux with no synchroniser.
`include "sclc_defs.vh"

module sclc_line_control (
  input  wire                      clk,
  input  wire                      arst_n,
  input  wire [`SCLC_ADDR_W-1:0]   reg_addr,
  input  wire [7:0]                reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [7:0]                reg_rdata,
  input  wire                      bypass_mode,
  input  wire                      auto_seq_mode,
  input  wire                      internal_sync_select,
  input  wire                      external_sync_select,
  input  wire                      aux_upper_dir,
  input  wire                      aux_lower_dir,
  input  wire                      seq_rst_level,
  input  wire                      int_gen_clk,
  input  wire                      ext_gen_clk,
  input  wire                      uart_io_out,
  input  wire                      uart_io_oe,
  input  wire                      uart_ext_io_out,
  input  wire                      uart_ext_io_oe,
  output reg                       card_rst,
  input  wire                      card_io_in,
  output reg                       card_io_out,
  output reg                       card_io_oe,
  input  wire                      aux_upper_in,
  output reg                       aux_upper_out,
  output reg                       aux_upper_oe,
  input  wire                      aux_lower_in,
  output reg                       aux_lower_out,
  output reg                       aux_lower_oe,
  output reg                       card_clk,
  input  wire                      ext_io_in,
  output reg                       ext_io_out,
  output reg                       ext_io_oe,
  output reg                       ext_clk
);

  // ****************************************
  // reset release
  // ****************************************
  reg                              rst_s1_q;
  reg                              rst_n;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  reg                              rst_ctl_q;
  reg                              io_wr_q;
  reg                              io_dir_q;
  reg                              auxu_q;
  reg                              auxl_q;
  reg                              park_q;
  reg                              stop_q;
  reg                              ext_io_wr_q;
  reg                              ext_dir_q;
  reg                              ext_park_q;
  reg                              ext_stop_q;

  localparam [7:0]                 card_ctl_init = `SCLC_RST_CARD_CTL;
  localparam [7:0]                 ext_ctl_init  = `SCLC_RST_EXT_CTL;

  wire                             sel_card;
  wire                             sel_ext;
  wire                             wr_card;
  wire                             wr_ext;

  assign sel_card = (reg_addr == `SCLC_OFF_CARD_CTL);
  assign sel_ext  = (reg_addr == `SCLC_OFF_EXT_CTL);
  assign wr_card  = reg_wr & sel_card;
  assign wr_ext   = reg_wr & sel_ext;

  // RULE20: reset values
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ctl_q <= card_ctl_init[`SCLC_CC_RST];
      io_wr_q   <= card_ctl_init[`SCLC_CC_IO];
      io_dir_q  <= card_ctl_init[`SCLC_CC_IOD];
      auxu_q    <= card_ctl_init[`SCLC_CC_AUXU];
      auxl_q    <= card_ctl_init[`SCLC_CC_AUXL];
      park_q    <= card_ctl_init[`SCLC_CC_PARK];
      stop_q    <= card_ctl_init[`SCLC_CC_STOP];
    end else if (wr_card) begin
      rst_ctl_q <= reg_wdata[`SCLC_CC_RST];
      io_wr_q   <= reg_wdata[`SCLC_CC_IO];
      io_dir_q  <= reg_wdata[`SCLC_CC_IOD];
      // RULE10: stored even when input
      auxu_q    <= reg_wdata[`SCLC_CC_AUXU];
      auxl_q    <= reg_wdata[`SCLC_CC_AUXL];
      park_q    <= reg_wdata[`SCLC_CC_PARK];
      stop_q    <= reg_wdata[`SCLC_CC_STOP];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_io_wr_q <= ext_ctl_init[`SCLC_EC_IO];
      ext_dir_q   <= ext_ctl_init[`SCLC_EC_IOD];
      ext_park_q  <= ext_ctl_init[`SCLC_EC_PARK];
      ext_stop_q  <= ext_ctl_init[`SCLC_EC_STOP];
    end else if (wr_ext) begin
      ext_io_wr_q <= reg_wdata[`SCLC_EC_IO];
      ext_dir_q   <= reg_wdata[`SCLC_EC_IOD];
      ext_park_q  <= reg_wdata[`SCLC_EC_PARK];
      ext_stop_q  <= reg_wdata[`SCLC_EC_STOP];
    end
  end

  // ****************************************
  // mode decode
  // ****************************************
  wire                             int_direct;
  wire                             ext_direct;
  wire                             int_sync;
  wire                             ext_sync;

  // RULE23: modes come from surrounding logic
  assign int_sync   = internal_sync_select & ~bypass_mode;
  assign ext_sync   = external_sync_select & ~bypass_mode;
  // RULE21: sync mode hands buffers to register
  assign int_direct = bypass_mode | int_sync;
  // RULE22: external buffer handed over
  assign ext_direct = bypass_mode | ext_sync;

  // ****************************************
  // card reset line
  // ****************************************
  reg                              card_rst_d;

  always @* begin
    if (int_sync) begin
      // RULE4: non-inverted, sequencer ignored
      card_rst_d = rst_ctl_q;
    end else if (auto_seq_mode) begin
      // RULE3: sequencer releases only while bit is 0
      card_rst_d = ~rst_ctl_q & seq_rst_level;
    end else begin
      // RULE1: bit 1 holds reset low
      card_rst_d = ~rst_ctl_q;
    end
  end

  // ****************************************
  // card and external clocks
  // ****************************************
  reg                              card_clk_d;
  reg                              ext_clk_d;

  always @* begin
    if (bypass_mode) begin
      // RULE12: park level is the line
      card_clk_d = park_q;
    end else if (stop_q) begin
      // RULE11: parked while stopped
      card_clk_d = park_q;
    end else begin
      // RULE13: running when stop bit is 0
      card_clk_d = int_gen_clk;
    end
  end

  always @* begin
    if (bypass_mode) begin
      // RULE18: park level drives line in bypass
      ext_clk_d = ext_park_q;
    end else if (ext_stop_q) begin
      // RULE17: disabled at park level
      ext_clk_d = ext_park_q;
    end else begin
      ext_clk_d = ext_gen_clk;
    end
  end

  // ****************************************
  // data and auxiliary lines
  // ****************************************
  reg                              card_io_out_d;
  reg                              card_io_oe_d;
  reg                              ext_io_out_d;
  reg                              ext_io_oe_d;

  always @* begin
    if (int_direct) begin
      // RULE6: written bit drives the line
      card_io_out_d = io_wr_q;
      // RULE8: 1 input, 0 output
      card_io_oe_d  = ~io_dir_q;
    end else begin
      card_io_out_d = uart_io_out;
      card_io_oe_d  = uart_io_oe;
    end
  end

  always @* begin
    if (ext_direct) begin
      // RULE14: drives pin when output
      ext_io_out_d = ext_io_wr_q;
      // RULE16: the buffer uses direction only here; ext_io_rd also uses it outside sync
      ext_io_oe_d  = ~ext_dir_q;
    end else begin
      ext_io_out_d = uart_ext_io_out;
      ext_io_oe_d  = uart_ext_io_oe;
    end
  end

  // pin outputs are registered so nothing glitches at the contacts
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      card_rst      <= 1'b0;
      card_clk      <= 1'b0;
      ext_clk       <= 1'b0;
      card_io_out   <= 1'b0;
      card_io_oe    <= 1'b0;
      ext_io_out    <= 1'b0;
      ext_io_oe     <= 1'b0;
      aux_upper_out <= 1'b0;
      aux_upper_oe  <= 1'b0;
      aux_lower_out <= 1'b0;
      aux_lower_oe  <= 1'b0;
    end else begin
      // RULE2: reset bit acts in every mode
      card_rst      <= card_rst_d;
      card_clk      <= card_clk_d;
      ext_clk       <= ext_clk_d;
      card_io_out   <= card_io_out_d;
      card_io_oe    <= card_io_oe_d;
      ext_io_out    <= ext_io_out_d;
      ext_io_oe     <= ext_io_oe_d;
      // RULE9: output contacts show the stored bit
      aux_upper_out <= auxu_q;
      aux_upper_oe  <= ~aux_upper_dir;
      aux_lower_out <= auxl_q;
      aux_lower_oe  <= ~aux_lower_dir;
    end
  end

  // ****************************************
  // sync mode capture
  // ****************************************
  wire                             int_edge;
  wire                             ext_edge;
  wire                             int_cap;
  wire                             ext_cap;

  // rising edge of the clock we are about to put on the contact
  assign int_edge = int_sync & card_clk_d & ~card_clk;
  assign ext_edge = ext_sync & ext_clk_d & ~ext_clk;

  // RULE7: card data at card clock rise
  sclc_edge_capture #(
    .RESET_VAL (1'b1)
  ) u_int_cap (
    .clk        (clk),
    .rst_n      (rst_n),
    .pin        (card_io_in),
    .edge_pulse (int_edge),
    .captured_q (int_cap)
  );

  // RULE15: external data at external clock rise
  sclc_edge_capture #(
    .RESET_VAL (1'b0)
  ) u_ext_cap (
    .clk        (clk),
    .rst_n      (rst_n),
    .pin        (ext_io_in),
    .edge_pulse (ext_edge),
    .captured_q (ext_cap)
  );

  // ****************************************
  // read mux
  // ****************************************
  reg                              io_rd;
  reg                              ext_io_rd;
  reg                              auxu_rd;
  reg                              auxl_rd;
  reg  [7:0]                       rdata_d;

  // RULE24: raw pins feed the mux; values may be metastable, as documented
  always @* begin
    if (int_sync) begin
      io_rd = int_cap;
    end else begin
      // RULE5: raw line level
      io_rd = card_io_in;
    end
    if (ext_sync) begin
      ext_io_rd = ext_cap;
    end else if (ext_dir_q) begin
      // RULE14: raw pin when input
      ext_io_rd = ext_io_in;
    end else begin
      ext_io_rd = ext_io_wr_q;
    end
    // RULE10: input contacts read raw
    auxu_rd = aux_upper_dir ? aux_upper_in : auxu_q;
    auxl_rd = aux_lower_dir ? aux_lower_in : auxl_q;
  end

  always @* begin
    rdata_d = `SCLC_RDATA_NONE;
    if (sel_card) begin
      rdata_d[`SCLC_CC_RST]  = rst_ctl_q;
      rdata_d[`SCLC_CC_IO]   = io_rd;
      rdata_d[`SCLC_CC_IOD]  = io_dir_q;
      rdata_d[`SCLC_CC_AUXU] = auxu_rd;
      rdata_d[`SCLC_CC_AUXL] = auxl_rd;
      rdata_d[`SCLC_CC_PARK] = park_q;
      rdata_d[`SCLC_CC_STOP] = stop_q;
    end else if (sel_ext) begin
      rdata_d[`SCLC_EC_IO]   = ext_io_rd;
      rdata_d[`SCLC_EC_IOD]  = ext_dir_q;
      rdata_d[`SCLC_EC_PARK] = ext_park_q;
      rdata_d[`SCLC_EC_STOP] = ext_stop_q;
    end
  end

  // data stands only in the cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `SCLC_RDATA_NONE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= `SCLC_RDATA_NONE;
    end
  end

endmodule

// ==== tb/sclc_line_control_sva.sv ====
`include "sclc_defs.vh"

module sclc_line_control_sva (
  input wire                    clk,
  input wire                    arst_n,
  input wire [`SCLC_ADDR_W-1:0] reg_addr,
  input wire [7:0]              reg_wdata,
  input wire                    reg_wr,
  input wire                    reg_rd,
  input wire [7:0]              reg_rdata,
  input wire                    bypass_mode,
  input wire                    auto_seq_mode,
  input wire                    internal_sync_select,
  input wire                    external_sync_select,
  input wire                    aux_upper_dir,
  input wire                    aux_lower_dir,
  input wire                    seq_rst_level,
  input wire                    int_gen_clk,
  input wire                    ext_gen_clk,
  input wire                    card_rst,
  input wire                    card_io_out,
  input wire                    card_io_oe,
  input wire                    aux_upper_in,
  input wire                    aux_upper_out,
  input wire                    aux_upper_oe,
  input wire                    aux_lower_in,
  input wire                    aux_lower_out,
  input wire                    aux_lower_oe,
  input wire                    card_clk,
  input wire                    ext_io_out,
  input wire                    ext_io_oe,
  input wire                    ext_clk
);
  // ****
  // register shadow
  // ****
  logic [7:0] cc_q;
  logic [7:0] ec_q;
  logic [2:0] up_q;
  logic       ok;
  logic       rst_e;
  logic       cclk_e;
  logic       eclk_e;
  logic [6:0] crd_e;
  logic [6:0] erd_e;

  // ok waits out the two-flop internal reset release
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cc_q <= `SCLC_RST_CARD_CTL;
      ec_q <= `SCLC_RST_EXT_CTL;
      up_q <= 3'h0;
    end else begin
      if (!up_q[2]) up_q <= up_q + 3'h1;
      if (reg_wr && reg_addr == `SCLC_OFF_CARD_CTL) cc_q <= reg_wdata;
      if (reg_wr && reg_addr == `SCLC_OFF_EXT_CTL) ec_q <= reg_wdata;
    end
  end
  assign ok     = up_q[2];
  assign rst_e  = (internal_sync_select && !bypass_mode) ? cc_q[7] :
                  (!cc_q[7] && (!auto_seq_mode || seq_rst_level));
  assign cclk_e = (bypass_mode || cc_q[0]) ? cc_q[1] : int_gen_clk;
  assign eclk_e = (bypass_mode || ec_q[0]) ? ec_q[1] : ext_gen_clk;
  assign crd_e  = {cc_q[7], 1'b0, cc_q[4], aux_upper_dir ? aux_upper_in : cc_q[3],
                   aux_lower_dir ? aux_lower_in : cc_q[2], cc_q[1:0]};
  assign erd_e  = {2'h0, ec_q[4], 2'h0, ec_q[1:0]};

  // ****
  // properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_card_rst_level: assert property (
    ok |-> card_rst == $past(rst_e)) else $error("card reset level wrong");
  a_card_clk_level: assert property (
    ok |-> card_clk == $past(cclk_e)) else $error("card clock level wrong");
  a_ext_clk_level: assert property (
    ok |-> ext_clk == $past(eclk_e)) else $error("external clock level wrong");
  a_card_io_dir: assert property (
    ok && $past(bypass_mode || internal_sync_select) |-> card_io_oe == !$past(cc_q[4]))
    else $error("card data direction wrong");
  a_card_io_drive: assert property (
    ok && $past(bypass_mode) && card_io_oe |-> card_io_out == $past(cc_q[5]))
    else $error("card data drive wrong");
  a_ext_io_dir: assert property (
    ok && $past(bypass_mode || external_sync_select) |-> ext_io_oe == !$past(ec_q[4]))
    else $error("external data direction wrong");
  a_ext_io_drive: assert property (
    ok && $past(bypass_mode) && ext_io_oe |-> ext_io_out == $past(ec_q[5]))
    else $error("external data drive wrong");
  a_aux_drive_dir: assert property (
    ok |-> {aux_upper_oe, aux_lower_oe} == ~$past({aux_upper_dir, aux_lower_dir}) &&
    (!aux_upper_oe || aux_upper_out == $past(cc_q[3])) &&
    (!aux_lower_oe || aux_lower_out == $past(cc_q[2]))) else $error("aux contact wrong");
  a_card_read_back: assert property (
    $past(reg_rd) && $past(reg_addr) == `SCLC_OFF_CARD_CTL |->
    {reg_rdata[7:6], reg_rdata[4:0]} == $past(crd_e)) else $error("card read wrong");
  a_ext_read_back: assert property (
    $past(reg_rd) && $past(reg_addr) == `SCLC_OFF_EXT_CTL |->
    {reg_rdata[7:6], reg_rdata[4:0]} == $past(erd_e)) else $error("ext read wrong");

  c_bypass_clk: cover property (bypass_mode && card_clk);
  c_sync_read: cover property (internal_sync_select && reg_rd);
  c_seq_hold: cover property (ok && auto_seq_mode && !seq_rst_level);
endmodule

bind sclc_line_control sclc_line_control_sva chk_u (
  .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bypass_mode,
  .auto_seq_mode, .internal_sync_select, .external_sync_select, .aux_upper_dir,
  .aux_lower_dir, .seq_rst_level, .int_gen_clk, .ext_gen_clk, .card_rst, .card_io_out,
  .card_io_oe, .aux_upper_in, .aux_upper_out, .aux_upper_oe, .aux_lower_in,
  .aux_lower_out, .aux_lower_oe, .card_clk, .ext_io_out, .ext_io_oe, .ext_clk
);

// ==== tb/sclc_card_model.sv ====
// ****
// card side contacts
// ****
// the card drives its own level whenever the block lets go of a line
module sclc_card_model (
  input  wire       card_io_out,
  input  wire       card_io_oe,
  input  wire       ext_io_out,
  input  wire       ext_io_oe,
  input  wire       aux_upper_out,
  input  wire       aux_upper_oe,
  input  wire       aux_lower_out,
  input  wire       aux_lower_oe,
  input  wire [3:0] card_lvl,
  output wire       card_io_in,
  output wire       ext_io_in,
  output wire       aux_upper_in,
  output wire       aux_lower_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign card_io_in   = card_io_oe ? card_io_out : card_lvl[0];
  assign ext_io_in    = ext_io_oe ? ext_io_out : card_lvl[1];
  assign aux_upper_in = aux_upper_oe ? aux_upper_out : card_lvl[2];
  assign aux_lower_in = aux_lower_oe ? aux_lower_out : card_lvl[3];
endmodule

// ==== tb/sclc_line_control_test.sv ====
`include "sclc_defs.vh"

module sclc_line_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] CC = `SCLC_OFF_CARD_CTL;
  localparam logic [15:0] EC = `SCLC_OFF_EXT_CTL;
  logic        clk       = 1'b0;
  logic        arst_n    = 1'b0;
  logic [15:0] reg_addr  = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [10:0] md        = 11'h000;
  logic [3:0]  lvl       = 4'hf;
  logic        gclk      = 1'b0;
  logic        gclk_q    = 1'b0;
  logic        gen_run   = 1'b0;
  logic [1:0]  gcnt      = 2'h0;
  logic        cap       = 1'b0;
  logic [7:0]  mcc       = `SCLC_RST_CARD_CTL;
  logic [7:0]  mec       = `SCLC_RST_EXT_CTL;
  logic [31:0] rs        = 32'h2d7c4c6f;
  int          bad_count = 0;
  int          compares  = 0;
  wire  [7:0]  reg_rdata;
  wire         cio_o, cio_e, cio_i, eio_o, eio_e, eio_i;
  wire         au_o, au_e, au_i, al_o, al_e, al_i;
  wire         crst, cclk, eclk;

  always #25 clk = ~clk;
  // link clock of 400 ns when running
  always @(posedge clk) begin
    if (gen_run) begin
      gcnt <= gcnt + 2'h1;
      if (gcnt == 2'h3) gclk <= ~gclk;
    end
  end
  // generator level the block saw one edge ago, as the clock pins are registered
  always @(posedge clk) gclk_q <= gclk;

  sclc_line_control dut_u (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bypass_mode(md[0]),
    .auto_seq_mode(md[1]), .internal_sync_select(md[2]), .external_sync_select(md[3]),
    .aux_upper_dir(md[4]), .aux_lower_dir(md[5]), .seq_rst_level(md[6]),
    .int_gen_clk(gclk), .ext_gen_clk(gclk), .uart_io_out(md[7]), .uart_io_oe(md[8]),
    .uart_ext_io_out(md[9]), .uart_ext_io_oe(md[10]), .card_rst(crst), .card_io_in(cio_i),
    .card_io_out(cio_o), .card_io_oe(cio_e), .aux_upper_in(au_i), .aux_upper_out(au_o),
    .aux_upper_oe(au_e), .aux_lower_in(al_i), .aux_lower_out(al_o), .aux_lower_oe(al_e),
    .card_clk(cclk), .ext_io_in(eio_i), .ext_io_out(eio_o), .ext_io_oe(eio_e),
    .ext_clk(eclk));

  sclc_card_model card_u (
    .card_io_out(cio_o), .card_io_oe(cio_e), .ext_io_out(eio_o), .ext_io_oe(eio_e),
    .aux_upper_out(au_o), .aux_upper_oe(au_e), .aux_lower_out(al_o), .aux_lower_oe(al_e),
    .card_lvl(lvl), .card_io_in(cio_i), .ext_io_in(eio_i), .aux_upper_in(au_i),
    .aux_lower_in(al_i));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // expected read value of each address from the model state
  function automatic logic [7:0] exp_rd(input logic [15:0] a);
    logic b5;
    if (a == CC) begin
      if (md[2] && !md[0]) b5 = cap;
      else if (md[0]) b5 = mcc[4] ? lvl[0] : mcc[5];
      else b5 = md[8] ? md[7] : lvl[0];
      return {mcc[7], 1'b0, b5, mcc[4], md[4] ? lvl[2] : mcc[3],
              md[5] ? lvl[3] : mcc[2], mcc[1:0]};
    end
    if (a != EC) return `SCLC_RDATA_NONE;
    if (md[3] && !md[0]) b5 = cap;
    else if (!mec[4]) b5 = mec[5];
    else b5 = (!md[0] && md[10]) ? md[9] : lvl[1];
    return {2'h0, b5, mec[4], 2'h0, mec[1:0]};
  endfunction

  task automatic print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == CC) mcc = d & 8'hbf;
    if (a == EC) mec = d & 8'h33;
  endtask

  // full low leaves out a sync-captured data bit of unknown history
  task automatic rdchk(input logic [15:0] a, input logic full);
    logic [7:0] m;
    logic [7:0] e;
    logic [2:0] p;
    m = full ? 8'hff : 8'hdf;
    repeat (2) @(posedge clk);
    e = exp_rd(a);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // read data stand until the next edge and are taken there
    @(posedge clk);
    chk(reg_rdata & m, e & m);
    p = {(md[2] && !md[0]) ? mcc[7] : (!mcc[7] && (!md[1] || md[6])),
         (md[0] || mcc[0]) ? mcc[1] : gclk_q,
         (md[0] || mec[0]) ? mec[1] : gclk_q};
    chk({5'h00, crst, cclk, eclk}, {5'h00, p});
  endtask

  initial begin
    #3000000;
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(CC, 1'b1);
    rdchk(EC, 1'b1);
    wr(16'hfe0c, 8'hff);
    rdchk(16'hfe0c, 1'b1);
    rdchk(CC, 1'b1);
    $display("test reset and unmapped done");
    for (int i = 0; i < 48; i++) begin
      rs = xs(rs);
      md   <= rs[10:0];
      lvl  <= rs[14:11];
      gclk <= rs[15];
      wr(CC, rs[23:16]);
      wr(EC, rs[31:24]);
      rdchk(CC, !(md[2] && !md[0]));
      rdchk(EC, !(md[3] && !md[0]));
    end
    $display("test random modes done");
    md <= 11'h03c;
    gclk <= 1'b0;
    wr(CC, 8'h10);
    wr(EC, 8'h10);
    for (int v = 0; v < 2; v++) begin
      lvl <= {2'h3, v[0], v[0]};
      repeat (4) @(posedge clk);
      gclk <= 1'b1;
      repeat (6) @(posedge clk);
      lvl <= {2'h3, !v[0], !v[0]};
      cap = v[0];
      gclk <= 1'b0;
      rdchk(CC, 1'b1);
      rdchk(EC, 1'b1);
    end
    $display("test sync capture done");
    md      <= 11'h040;
    gen_run <= 1'b1;
    wr(CC, 8'h3e);
    wr(EC, 8'h12);
    repeat (20) @(posedge clk);
    md <= 11'h002;
    repeat (20) @(posedge clk);
    md <= 11'h042;
    wr(CC, 8'hb1);
    wr(EC, 8'h13);
    rdchk(CC, 1'b1);
    rdchk(EC, 1'b1);
    $display("test clock run and stop done");
    print_verdict();
  end
endmodule
